// ### rtl/alf_core.sv
/*
  Address lookup and forwarding core: learning table, aging, two-stage
  destination resolution, buffer pool accounting, APB registers.
  Assumes each frame descriptor is presented only after the whole frame
  sits in the buffer pool, and the queue logic returns buffers it drains.
*/
`timescale 1ns/1ps
module alf_core #(
  parameter int DEPTH = alf_pkg::TBL_DEPTH,
  parameter int TICK_CYCLES = alf_pkg::TICK_CYCLES,
  parameter int EPOCH_TICKS = alf_pkg::EPOCH_TICKS,
  parameter int BUFS = alf_pkg::BUF_TOTAL
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Received frame descriptor
  input wire logic frm_valid,
  output logic frm_ready,
  input wire logic [2:0] frm_src_port,
  input wire logic [47:0] frm_sa,
  input wire logic [47:0] frm_da,
  input wire logic [6:0] vlan_filter_group_id,
  input wire logic no_process_vlan_check,
  input wire logic [3:0] frm_err,
  input wire logic frm_pause,
  input wire logic frm_igmp,
  input wire logic frm_bpdu,
  input wire logic frm_acl_hit,
  input wire logic [4:0] frm_acl_set,
  input wire logic [4:0] frm_nbuf,
  // Forwarding result
  output logic fwd_valid,
  output logic [4:0] final_egress_port_set,
  output logic [4:0] fwd_nbuf,
  input wire logic fwd_ready,
  // Buffer return
  input wire logic buf_rel_valid,
  input wire logic [4:0] buf_rel_cnt
);
  localparam int IW = $clog2(DEPTH);
  localparam logic [4:0] HOST_BIT = 5'(1 << alf_pkg::HOST_PORT);
  localparam logic [4:0] ALL_PORTS = 5'h1F;

  alf_pkg::alf_state_e state_r, state_nxt;
  logic [31:0] gctrl_r, port_en_r, mirror_r, vlan_r;
  logic [31:0] st_lo_r [alf_pkg::STATIC_N];
  logic [31:0] st_hi_r [alf_pkg::STATIC_N];
  logic [31:0] prdata_r;
  logic pready_r, pslverr_r;
  // Table storage
  logic [47:0] tbl_mac_r [DEPTH];
  logic [2:0] tbl_port_r [DEPTH];
  logic [6:0] tbl_fid_r [DEPTH];
  logic [2:0] tbl_stamp_r [DEPTH];
  logic [DEPTH-1:0] tbl_vld_r;
  logic [10:0] count_r;
  // Latched frame
  logic [2:0] src_r;
  logic [47:0] sa_r, da_r;
  logic [6:0] fid_r;
  logic nvid_r, err_r, pause_r, igmp_r, bpdu_r, acl_r;
  logic [4:0] acl_set_r, nbuf_r;
  // Scan results
  logic [IW-1:0] scan_idx_r, sa_idx_r, free_idx_r, age_idx_r;
  logic sa_hit_r, da_hit_r, free_hit_r;
  logic [2:0] sa_port_r, da_port_r;
  // Aging time base
  logic [31:0] tick_cnt_r, epoch_cnt_r;
  logic [2:0] epoch_r;
  // Pool and outputs
  logic [9:0] free_r, free_nxt;
  logic frm_ready_r, fwd_valid_r;
  logic [4:0] fwd_set_r, fwd_nbuf_r, set_c;
  logic take, drop_c, local_c, mir_add_c, good_c;

  assign take = frm_valid && frm_ready_r;
  assign good_c = !err_r;

  function automatic logic apb_hit(input logic [7:0] a, input logic [7:0] base);
    apb_hit = (a == base);
  endfunction

  function automatic logic key_match(input logic [47:0] m, input logic [6:0] f,
                                     input logic [47:0] k, input logic [6:0] kf,
                                     input logic use_fid);
    key_match = (m == k) && (!use_fid || f == kf);
  endfunction

  // APB registers: one access cycle, never waits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gctrl_r <= alf_pkg::GCTRL3_RST;
      port_en_r <= alf_pkg::PORT_EN_RST;
      mirror_r <= alf_pkg::MIRROR_RST;
      vlan_r <= alf_pkg::VLAN_RST;
      for (int k = 0; k < alf_pkg::STATIC_N; k++) begin
        st_lo_r[k] <= 32'h0000_0000;
        st_hi_r[k] <= 32'h0000_0000;
      end
    end else if (psel && penable && pready_r && pwrite) begin
      if (apb_hit(paddr, alf_pkg::A_GCTRL3)) begin
        gctrl_r <= pwdata & 32'h0000_0005;
      end
      if (apb_hit(paddr, alf_pkg::A_PORT_EN)) begin
        port_en_r <= pwdata & 32'h1F1F_1F1F;
      end
      if (apb_hit(paddr, alf_pkg::A_MIRROR)) begin
        mirror_r <= pwdata & 32'h0307_1F1F;
      end
      if (apb_hit(paddr, alf_pkg::A_VLAN)) begin
        vlan_r <= pwdata & 32'h01FF_FFFF;
      end
      for (int k = 0; k < alf_pkg::STATIC_N; k++) begin
        if (apb_hit(paddr, alf_pkg::A_STATIC + 8'(8 * k))) begin
          st_lo_r[k] <= pwdata;
        end
        if (apb_hit(paddr, alf_pkg::A_STATIC + 8'(8 * k + 4))) begin
          st_hi_r[k] <= pwdata & 32'h801F_FFFF;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else begin
      pready_r <= psel && !penable;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
      if (psel && !penable) begin
        pslverr_r <= 1'b1;
        if (apb_hit(paddr, alf_pkg::A_GCTRL3) || apb_hit(paddr, alf_pkg::A_PORT_EN)
            || apb_hit(paddr, alf_pkg::A_MIRROR) || apb_hit(paddr, alf_pkg::A_VLAN)
            || apb_hit(paddr, alf_pkg::A_STATUS)) begin
          pslverr_r <= 1'b0;
        end
        if (apb_hit(paddr, alf_pkg::A_GCTRL3)) begin
          prdata_r <= gctrl_r;
        end
        if (apb_hit(paddr, alf_pkg::A_PORT_EN)) begin
          prdata_r <= port_en_r;
        end
        if (apb_hit(paddr, alf_pkg::A_MIRROR)) begin
          prdata_r <= mirror_r;
        end
        if (apb_hit(paddr, alf_pkg::A_VLAN)) begin
          prdata_r <= vlan_r;
        end
        if (apb_hit(paddr, alf_pkg::A_STATUS)) begin
          prdata_r <= {6'h00, free_r, 5'h00, count_r};
        end
        for (int k = 0; k < alf_pkg::STATIC_N; k++) begin
          if (apb_hit(paddr, alf_pkg::A_STATIC + 8'(8 * k))) begin
            prdata_r <= st_lo_r[k];
            pslverr_r <= 1'b0;
          end
          if (apb_hit(paddr, alf_pkg::A_STATIC + 8'(8 * k + 4))) begin
            prdata_r <= st_hi_r[k];
            pslverr_r <= 1'b0;
          end
        end
      end
    end
  end

  // Aging time base: 1 ms ticks, 75 s epochs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_r <= 32'h0000_0000;
      epoch_cnt_r <= 32'h0000_0000;
      epoch_r <= 3'h0;
    end else if (tick_cnt_r == 32'(TICK_CYCLES - 1)) begin
      tick_cnt_r <= 32'h0000_0000;
      if (epoch_cnt_r == 32'(EPOCH_TICKS - 1)) begin
        epoch_cnt_r <= 32'h0000_0000;
        epoch_r <= epoch_r + 3'h1;
      end else begin
        epoch_cnt_r <= epoch_cnt_r + 32'h0000_0001;
      end
    end else begin
      tick_cnt_r <= tick_cnt_r + 32'h0000_0001;
    end
  end

  // Control sequence
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      alf_pkg::S_IDLE: if (take) state_nxt = alf_pkg::S_SCAN;
      alf_pkg::S_SCAN: if (scan_idx_r == IW'(DEPTH - 1)) state_nxt = alf_pkg::S_LEARN;
      alf_pkg::S_LEARN: state_nxt = alf_pkg::S_RESOLVE;
      alf_pkg::S_RESOLVE: state_nxt = (set_c == 5'h00) ? alf_pkg::S_IDLE : alf_pkg::S_OUT;
      alf_pkg::S_OUT: if (fwd_ready) state_nxt = alf_pkg::S_IDLE;
      default: state_nxt = alf_pkg::S_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= alf_pkg::S_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Frame capture and full table scan
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {src_r, sa_r, da_r, fid_r, nvid_r, err_r, pause_r} <= '0;
      {igmp_r, bpdu_r, acl_r, acl_set_r, nbuf_r} <= '0;
      {scan_idx_r, sa_idx_r, free_idx_r, sa_hit_r, da_hit_r, free_hit_r} <= '0;
      {sa_port_r, da_port_r} <= '0;
    end else if (take) begin
      src_r <= frm_src_port;
      sa_r <= frm_sa;
      da_r <= frm_da;
      fid_r <= vlan_filter_group_id;
      nvid_r <= no_process_vlan_check;
      err_r <= |frm_err;
      {pause_r, igmp_r, bpdu_r, acl_r} <= {frm_pause, frm_igmp, frm_bpdu, frm_acl_hit};
      acl_set_r <= frm_acl_set;
      nbuf_r <= frm_nbuf;
      {scan_idx_r, sa_hit_r, da_hit_r, free_hit_r} <= '0;
    end else if (state_r == alf_pkg::S_SCAN) begin
      scan_idx_r <= scan_idx_r + IW'(1);
      if (tbl_vld_r[scan_idx_r]) begin
        if (key_match(tbl_mac_r[scan_idx_r], tbl_fid_r[scan_idx_r], sa_r, fid_r,
                      gctrl_r[alf_pkg::GC_KEY_FID])) begin
          sa_hit_r <= 1'b1;
          sa_idx_r <= scan_idx_r;
          sa_port_r <= tbl_port_r[scan_idx_r];
        end
        if (key_match(tbl_mac_r[scan_idx_r], tbl_fid_r[scan_idx_r], da_r, fid_r,
                      gctrl_r[alf_pkg::GC_KEY_FID])) begin
          da_hit_r <= 1'b1;
          da_port_r <= tbl_port_r[scan_idx_r];
        end
      end else if (!free_hit_r) begin
        free_hit_r <= 1'b1;
        free_idx_r <= scan_idx_r;
      end
    end
  end

  // Table valid bits, entry count, learning and aging
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tbl_vld_r <= '0;
      count_r <= 11'h000;
      age_idx_r <= '0;
    end else if (state_r == alf_pkg::S_LEARN) begin
      // insert only unknown on good frame
      if (!sa_hit_r && good_c) begin
        tbl_vld_r[free_hit_r ? free_idx_r : IW'(DEPTH - 1)] <= 1'b1;
        if (free_hit_r) begin
          count_r <= count_r + 11'h001;
        end
      end
    end else if (state_r == alf_pkg::S_IDLE && gctrl_r[alf_pkg::GC_AGE_EN]) begin
      age_idx_r <= age_idx_r + IW'(1);
      // delete stale entries; long aging-off spans may wrap the stamp
      if (tbl_vld_r[age_idx_r] && (epoch_r - tbl_stamp_r[age_idx_r]) >= alf_pkg::AGE_EPOCHS) begin
        tbl_vld_r[age_idx_r] <= 1'b0;
        count_r <= count_r - 11'h001;
      end
    end
  end

  always_ff @(posedge pclk) begin
    if (state_r == alf_pkg::S_LEARN) begin
      if (sa_hit_r) begin
        tbl_stamp_r[sa_idx_r] <= epoch_r;
        if (good_c && sa_port_r != src_r) begin
          tbl_port_r[sa_idx_r] <= src_r;
        end
      end else if (good_c) begin
        // store entry, last slot when full
        tbl_mac_r[free_hit_r ? free_idx_r : IW'(DEPTH - 1)] <= sa_r;
        tbl_port_r[free_hit_r ? free_idx_r : IW'(DEPTH - 1)] <= src_r;
        tbl_fid_r[free_hit_r ? free_idx_r : IW'(DEPTH - 1)] <= fid_r;
        tbl_stamp_r[free_hit_r ? free_idx_r : IW'(DEPTH - 1)] <= epoch_r;
      end
    end
  end

  // Destination resolution
  always_comb begin
    logic st_hit;
    logic [4:0] src_bit, sniff_tx;
    logic rx_m, tx_m;
    st_hit = 1'b0;
    sniff_tx = 5'h00;
    rx_m = 1'b0;
    tx_m = 1'b0;
    src_bit = 5'b00001 << src_r;
    set_c = 5'h00;
    local_c = 1'b0;
    mir_add_c = 1'b0;
    for (int k = 0; k < alf_pkg::STATIC_N; k++) begin
      if (!st_hit && st_hi_r[k][alf_pkg::SE_VLD] && st_lo_r[k] == da_r[31:0]
          && st_hi_r[k][15:0] == da_r[47:32]) begin
        st_hit = 1'b1;
        set_c = st_hi_r[k][alf_pkg::SE_SET +: 5];
      end
    end
    if (!st_hit) begin
      set_c = da_hit_r ? (5'b00001 << da_port_r) : ALL_PORTS;
    end
    local_c = (set_c == src_bit);
    if (igmp_r) begin
      set_c = HOST_BIT;
      local_c = 1'b0;
    end
    if (bpdu_r) begin
      set_c = HOST_BIT;
      local_c = 1'b0;
    end
    set_c = set_c & ~src_bit;
    if (!nvid_r && src_r < 3'(alf_pkg::NPORT)) begin
      set_c = set_c & vlan_r[5 * src_r +: 5];
    end
    if (!bpdu_r) begin
      set_c = set_c & port_en_r[alf_pkg::PE_STP +: 5];
      if (!port_en_r[alf_pkg::PE_STP + src_r]) begin
        set_c = 5'h00;
      end
    end
    set_c = set_c & port_en_r[alf_pkg::PE_TX +: 5];
    if (!port_en_r[alf_pkg::PE_RX + src_r] || src_r >= 3'(alf_pkg::NPORT)) begin
      set_c = 5'h00;
    end
    sniff_tx = mirror_r[alf_pkg::MR_TX +: 5];
    rx_m = mirror_r[alf_pkg::MR_RX + src_r];
    tx_m = |(set_c & sniff_tx);
    case (alf_pkg::alf_mir_e'(mirror_r[alf_pkg::MR_MODE +: 2]))
      alf_pkg::MIR_RX: mir_add_c = rx_m;
      alf_pkg::MIR_TX: mir_add_c = tx_m;
      alf_pkg::MIR_RX_OR_TX: mir_add_c = rx_m || tx_m;
      alf_pkg::MIR_RX_AND_TX: mir_add_c = rx_m && tx_m;
      default: mir_add_c = 1'b0;
    endcase
    mir_add_c = mir_add_c && !local_c && set_c != 5'h00;
    if (local_c) begin
      set_c = 5'h00;
    end
    if (mir_add_c) begin
      set_c = set_c | (5'b00001 << mirror_r[alf_pkg::MR_SNIF +: 3]);
    end
    if (!port_en_r[alf_pkg::PE_AUTH + src_r]) begin
      set_c = 5'h00;
    end
    if (acl_r) begin
      set_c = acl_set_r;
    end
    drop_c = err_r || pause_r;
    if (drop_c) begin
      set_c = 5'h00;
    end
  end

  // Buffer pool accounting
  always_comb begin
    free_nxt = free_r;
    if (take) begin
      free_nxt = free_nxt - 10'(frm_nbuf);
    end
    if (buf_rel_valid) begin
      free_nxt = free_nxt + 10'(buf_rel_cnt);
    end
    if (state_r == alf_pkg::S_RESOLVE && set_c == 5'h00) begin
      free_nxt = free_nxt + 10'(nbuf_r);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      free_r <= 10'(BUFS);
      frm_ready_r <= 1'b0;
      fwd_valid_r <= 1'b0;
      fwd_set_r <= 5'h00;
      fwd_nbuf_r <= 5'h00;
    end else begin
      free_r <= free_nxt;
      frm_ready_r <= state_nxt == alf_pkg::S_IDLE && !take
                     && free_nxt >= 10'(alf_pkg::MAX_FRAME_BUFS);
      if (state_r == alf_pkg::S_RESOLVE && set_c != 5'h00) begin
        fwd_valid_r <= 1'b1;
        fwd_set_r <= set_c;
        fwd_nbuf_r <= nbuf_r;
      end else if (fwd_valid_r && fwd_ready) begin
        fwd_valid_r <= 1'b0;
      end
    end
  end

  assign frm_ready = frm_ready_r;
  assign fwd_valid = fwd_valid_r;
  assign final_egress_port_set = fwd_set_r;
  assign fwd_nbuf = fwd_nbuf_r;
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;

  chk_pool_bound: assert property (@(posedge pclk) disable iff (!presetn)
    free_r <= 10'(BUFS)) else $error("buffer pool above capacity");
  chk_error_drop: assert property (@(posedge pclk) disable iff (!presetn)
    state_r == alf_pkg::S_RESOLVE && err_r |=> !fwd_valid_r && state_r == alf_pkg::S_IDLE)
    else $error("error frame forwarded");
  chk_pause_drop: assert property (@(posedge pclk) disable iff (!presetn)
    fwd_valid_r |-> !pause_r) else $error("pause frame forwarded");
  chk_local_drop: assert property (@(posedge pclk) disable iff (!presetn)
    state_r == alf_pkg::S_RESOLVE && local_c && !acl_r |=> state_r == alf_pkg::S_IDLE)
    else $error("local frame forwarded");
  chk_learn_new: assert property (@(posedge pclk) disable iff (!presetn)
    state_r == alf_pkg::S_LEARN && !sa_hit_r && good_c && free_hit_r
    |=> tbl_vld_r[free_idx_r] && tbl_mac_r[free_idx_r] == sa_r)
    else $error("new source not learned");
  chk_migrate_port: assert property (@(posedge pclk) disable iff (!presetn)
    state_r == alf_pkg::S_LEARN && sa_hit_r && good_c |=> tbl_port_r[sa_idx_r] == src_r)
    else $error("migration not recorded");
  chk_stamp_refresh: assert property (@(posedge pclk) disable iff (!presetn)
    state_r == alf_pkg::S_LEARN && sa_hit_r |=> tbl_stamp_r[sa_idx_r] == $past(epoch_r))
    else $error("stamp not refreshed");
  chk_acl_priority: assert property (@(posedge pclk) disable iff (!presetn)
    state_r == alf_pkg::S_RESOLVE && acl_r && !drop_c && acl_set_r != 5'h00
    |=> fwd_valid_r && fwd_set_r == $past(acl_set_r)) else $error("ACL set not used");
  chk_aging_off: assert property (@(posedge pclk) disable iff (!presetn)
    !gctrl_r[alf_pkg::GC_AGE_EN] && state_r == alf_pkg::S_IDLE |=> $stable(age_idx_r))
    else $error("aging ran while disabled");
endmodule

// ### rtl/alf_pkg.sv
/*
  Shared constants for the address lookup and forwarding core: APB map,
  field positions, reset values, table and buffer pool sizes, timing.
  Assumes a 200 MHz core clock.
*/
package alf_pkg;
  // Ports, host uplink, table
  localparam int NPORT = 5;
  localparam int HOST_PORT = 4;
  localparam int TBL_DEPTH = 1024;
  localparam int STATIC_N = 4;
  // Buffer pool: 512 x 128 bytes = 64 kB
  localparam int BUF_TOTAL = 512;
  localparam int BUF_BYTES = 128;
  localparam int MAX_FRAME_BYTES = 2048;
  localparam int MAX_FRAME_BUFS = MAX_FRAME_BYTES / BUF_BYTES;
  // Timing
  localparam int CLK_MHZ = 200;
  localparam int TICK_US = 1000;
  localparam int TICK_CYCLES = CLK_MHZ * TICK_US;
  localparam int AGE_PERIOD_S = 300;
  localparam int AGE_TOL_S = 75;
  localparam int EPOCH_TICKS = AGE_TOL_S * (1000000 / TICK_US);
  localparam logic [2:0] AGE_EPOCHS = 3'(AGE_PERIOD_S / AGE_TOL_S);
  // Register offsets
  localparam logic [7:0] A_GCTRL3 = 8'h0C;
  localparam logic [7:0] A_PORT_EN = 8'h10;
  localparam logic [7:0] A_MIRROR = 8'h14;
  localparam logic [7:0] A_VLAN = 8'h18;
  localparam logic [7:0] A_STATUS = 8'h1C;
  localparam logic [7:0] A_STATIC = 8'h20;
  // Field positions
  localparam int GC_KEY_FID = 0;
  localparam int GC_AGE_EN = 2;
  localparam int PE_RX = 0;
  localparam int PE_TX = 8;
  localparam int PE_STP = 16;
  localparam int PE_AUTH = 24;
  localparam int MR_RX = 0;
  localparam int MR_TX = 8;
  localparam int MR_SNIF = 16;
  localparam int MR_MODE = 24;
  localparam int ST_CNT = 0;
  localparam int ST_FREE = 16;
  localparam int SE_SET = 16;
  localparam int SE_VLD = 31;
  // Reset values
  localparam logic [31:0] GCTRL3_RST = 32'h0000_0004;
  localparam logic [31:0] PORT_EN_RST = 32'h1F1F_1F1F;
  localparam logic [31:0] MIRROR_RST = 32'h0000_0000;
  localparam logic [31:0] VLAN_RST = 32'h01FF_FFFF;
  typedef enum logic [1:0] {
    MIR_RX = 2'b00,
    MIR_TX = 2'b01,
    MIR_RX_OR_TX = 2'b10,
    MIR_RX_AND_TX = 2'b11
  } alf_mir_e;
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_SCAN = 3'b001,
    S_LEARN = 3'b010,
    S_RESOLVE = 3'b011,
    S_OUT = 3'b100
  } alf_state_e;
endpackage

// ### verif/alf_mac_model.sv
/*
  Partner model: the port MACs offering descriptors of received frames.
  Assumes one bench thread calls send, right after a rising edge.
*/
`timescale 1ns/1ps
module alf_mac_model (
  // Clock
  input wire logic pclk,
  // Descriptor handshake
  output logic frm_valid,
  input wire logic frm_ready,
  output logic [2:0] frm_src_port,
  output logic [47:0] frm_sa,
  output logic [47:0] frm_da
);
  initial begin
    frm_valid = 1'b0;
    frm_src_port = 3'h0;
    frm_sa = 48'h0000_0000_0000;
    frm_da = 48'h0000_0000_0000;
  end
  task automatic send(input logic [2:0] p, input logic [47:0] sa, input logic [47:0] da,
                      output bit ok);
    ok = 1'b0;
    @(posedge pclk);
    frm_valid <= 1'b1;
    frm_src_port <= p;
    frm_sa <= sa;
    frm_da <= da;
    for (int i = 0; i < 100 && !ok; i++) begin
      @(posedge pclk);
      ok = (frm_ready === 1'b1);
    end
    // Flipped so a stale field never looks valid
    frm_valid <= 1'b0;
    frm_src_port <= ~p;
    frm_sa <= ~sa;
    frm_da <= ~da;
  endtask
endmodule

// ### verif/testbench.sv
/*
  Testbench of the lookup and forwarding core: registers, learning, drops,
  migration, pool accounting, aging.
  Assumes a 16-entry table and short tick and epoch counts.
*/
`timescale 1ns/1ps
module testbench;
  localparam logic [47:0] MA = 48'h0000_1111_0001;
  localparam logic [47:0] MB = 48'h0000_2222_0002;
  localparam logic [47:0] MC = 48'h0000_3333_0003;
  localparam logic [47:0] MD = 48'h0000_4444_0004;
  localparam logic [47:0] ME = 48'h0000_5555_0005;
  localparam logic [47:0] MU = 48'h0000_6666_0006;
  localparam logic [47:0] SB = 48'h0000_7777_0000;
  localparam logic [47:0] SF = 48'h0000_7777_000F;
  localparam logic [47:0] SG = 48'h0000_7777_0010;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rdv;
  logic pready, pslverr, frm_valid, frm_ready, fwd_valid, erv;
  logic [2:0] frm_src_port;
  logic [47:0] frm_sa, frm_da;
  logic [6:0] vlan_filter_group_id = 7'h00;
  logic no_process_vlan_check = 1'b0, frm_pause = 1'b0, frm_igmp = 1'b0, frm_bpdu = 1'b0;
  logic frm_acl_hit = 1'b0, fwd_ready = 1'b1, buf_rel_valid = 1'b0, hold = 1'b0;
  logic [3:0] frm_err = 4'h0;
  logic [4:0] frm_acl_set = 5'h00, frm_nbuf = 5'h01, final_egress_port_set, fwd_nbuf;
  logic [4:0] buf_rel_cnt = 5'h00, st, nb;
  int n_fail = 0;
  int total_checks = 0;
  always #2.5 pclk = ~pclk;
  alf_core #(.DEPTH(16), .TICK_CYCLES(4), .EPOCH_TICKS(2), .BUFS(512)) dut_u (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .frm_valid, .frm_ready, .frm_src_port, .frm_sa, .frm_da,
    .vlan_filter_group_id, .no_process_vlan_check, .frm_err, .frm_pause, .frm_igmp,
    .frm_bpdu, .frm_acl_hit, .frm_acl_set, .frm_nbuf, .fwd_valid,
    .final_egress_port_set, .fwd_nbuf, .fwd_ready, .buf_rel_valid, .buf_rel_cnt);
  alf_mac_model mac_u (.pclk, .frm_valid, .frm_ready, .frm_src_port, .frm_sa, .frm_da);
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      n_fail++;
      give_verdict();
    end
    rdv = prdata;
    erv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic stat(input logic [31:0] e);
    apb(1'b0, alf_pkg::A_STATUS, 32'h0000_0000);
    chk("status", rdv, e);
  endtask
  // Offers a frame; egress set lands in st, zero when dropped
  task automatic fchk(input logic [2:0] p, input logic [47:0] sa, input logic [47:0] da,
                      input logic [4:0] exp);
    bit ok;
    int i;
    st = 5'h00;
    mac_u.send(p, sa, da, ok);
    for (i = 0; i < 60 && ok; i++) begin
      @(posedge pclk);
      if (fwd_valid === 1'b1) begin
        st = final_egress_port_set;
        nb = fwd_nbuf;
      end
      if (frm_ready === 1'b1) break;
    end
    if (!ok || i == 60) begin
      n_fail++;
      give_verdict();
    end
    // Queue side hands buffers back unless a test holds them
    if (st != 5'h00 && !hold) begin
      buf_rel_valid <= 1'b1;
      buf_rel_cnt <= nb;
      @(posedge pclk);
      buf_rel_valid <= 1'b0;
    end
    chk("egress set", 32'(st), 32'(exp));
  endtask
  task automatic t_regs();
    logic [7:0] a [6] = '{alf_pkg::A_GCTRL3, alf_pkg::A_PORT_EN, alf_pkg::A_MIRROR,
                          alf_pkg::A_VLAN, alf_pkg::A_STATUS, 8'h40};
    logic [31:0] e [6] = '{alf_pkg::GCTRL3_RST, alf_pkg::PORT_EN_RST, alf_pkg::MIRROR_RST,
                           alf_pkg::VLAN_RST, 32'h0200_0000, 32'h0000_0000};
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, a[i], 32'h0000_0000);
      chk("reg read", rdv, e[i]);
      chk("slave error", 32'(erv), 32'(i == 5));
    end
  endtask
  task automatic t_learn();
    apb(1'b1, alf_pkg::A_GCTRL3, 32'h0000_0000);
    fchk(3'h1, MA, MU, 5'h1D);
    stat(32'h0200_0001);
    fchk(3'h2, MB, MA, 5'h02);
    fchk(3'h1, MC, MA, 5'h00);
    stat(32'h0200_0003);
  endtask
  task automatic t_drop();
    for (int k = 0; k < 4; k++) begin
      frm_err <= 4'(1 << k);
      fchk(3'h0, MD, MU, 5'h00);
    end
    frm_err <= 4'h0;
    frm_pause <= 1'b1;
    fchk(3'h0, MA, MU, 5'h00);
    frm_pause <= 1'b0;
    stat(32'h0200_0003);
    frm_igmp <= 1'b1;
    fchk(3'h0, MB, MU, 5'h10);
    frm_igmp <= 1'b0;
    frm_acl_hit <= 1'b1;
    frm_acl_set <= 5'h06;
    fchk(3'h0, MB, MA, 5'h06);
    frm_acl_hit <= 1'b0;
  endtask
  task automatic t_migrate();
    fchk(3'h3, MA, MU, 5'h17);
    fchk(3'h0, MB, MA, 5'h08);
    apb(1'b1, alf_pkg::A_STATIC, ME[31:0]);
    apb(1'b1, 8'h24, {1'b1, 10'h000, 5'h04, ME[47:32]});
    fchk(3'h1, ME, MU, 5'h1D);
    fchk(3'h0, MB, ME, 5'h04);
  endtask
  task automatic t_pool();
    hold = 1'b1;
    frm_nbuf <= 5'h03;
    fchk(3'h2, MB, MA, 5'h08);
    chk("buffers", 32'(nb), 32'h0000_0003);
    stat(32'h01FD_0004);
    buf_rel_valid <= 1'b1;
    buf_rel_cnt <= 5'h03;
    @(posedge pclk);
    buf_rel_valid <= 1'b0;
    hold = 1'b0;
    stat(32'h0200_0004);
  endtask
  task automatic t_age();
    repeat (200) @(posedge pclk);
    stat(32'h0200_0004);
    apb(1'b1, alf_pkg::A_GCTRL3, 32'h0000_0004);
    repeat (300) @(posedge pclk);
    stat(32'h0200_0000);
  endtask
  // Full table, mirror modes, enables, VLAN, filter group key
  task automatic t_class();
    apb(1'b1, alf_pkg::A_GCTRL3, 32'h0000_0000);
    for (int k = 0; k < 17; k++) begin
      fchk((k == 16) ? 3'h3 : 3'h0, SB + 48'(k), MU, (k == 16) ? 5'h17 : 5'h1E);
    end
    stat(32'h0200_0010);
    fchk(3'h0, SB, SG, 5'h08);
    fchk(3'h0, SB, SF, 5'h1E);
    apb(1'b1, alf_pkg::A_MIRROR, 32'h0304_0401);
    fchk(3'h0, SB, SG, 5'h08);
    apb(1'b1, alf_pkg::A_MIRROR, 32'h0204_0401);
    fchk(3'h0, SB, SG, 5'h18);
    apb(1'b1, alf_pkg::A_MIRROR, 32'h0000_0000);
    apb(1'b1, alf_pkg::A_PORT_EN, 32'h1F1E_171F);
    fchk(3'h0, SB, SF, 5'h00);
    frm_bpdu <= 1'b1;
    fchk(3'h0, SB, SG, 5'h10);
    frm_bpdu <= 1'b0;
    fchk(3'h1, SB + 48'h0000_0000_0001, SG, 5'h00);
    apb(1'b1, alf_pkg::A_PORT_EN, alf_pkg::PORT_EN_RST);
    apb(1'b1, alf_pkg::A_VLAN, 32'h01FF_FFF1);
    fchk(3'h0, SB, SG, 5'h00);
    no_process_vlan_check <= 1'b1;
    fchk(3'h0, SB, SG, 5'h08);
    no_process_vlan_check <= 1'b0;
    apb(1'b1, alf_pkg::A_VLAN, alf_pkg::VLAN_RST);
    apb(1'b1, alf_pkg::A_GCTRL3, 32'h0000_0001);
    vlan_filter_group_id <= 7'h05;
    fchk(3'h0, SB, SG, 5'h1E);
    fchk(3'h2, MU, SB, 5'h01);
    vlan_filter_group_id <= 7'h00;
  endtask
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_learn();
    t_drop();
    t_migrate();
    t_pool();
    t_age();
    t_class();
    give_verdict();
  end
endmodule
